// >>> mhp_pkg.sv
// package for the modem handshake pin block: register field positions and reset values
// assumes one clock domain; no bus, fields reach the core as plain ports
package mhp_pkg;
    localparam int MHP_MSR_W = 8;
    localparam int MHP_MSR_CTS_CHANGE_FLAG_BIT = 0;
    localparam int MHP_MSR_DSR_CHANGE_FLAG_BIT = 1;
    localparam int MHP_MSR_CTS_BIT = 4;
    localparam int MHP_MSR_DSR_BIT = 5;
    localparam int MHP_MCR_W = 8;
    localparam int MHP_MCR_DTR_BIT = 0;
    localparam logic [7:0] MHP_MCR_RST = 8'h00;
    localparam logic [7:0] MHP_MSR_RST = 8'h00;
    localparam logic MHP_MARK = 1'h1;
    localparam logic MHP_SPACE = 1'h0;
    localparam int MHP_SYNC_STAGES = 2;
endpackage : mhp_pkg

// >>> mhp_sync.sv
// two-stage synchroniser for a bank of asynchronous pin inputs
// assumes pins are asynchronous to mclk_in; reset value is a parameter constant
`timescale 1ns/1ps
`default_nettype none
module mhp_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule : mhp_sync
`default_nettype wire

// >>> mhp_modem_pins.sv
// modem handshake pins: serial line idle forcing, clear-to-send and data-set-ready status,
// and data-terminal-ready control.
// assumes a single 40 MHz clock; cpu side strobes are one-cycle pulses from same-clock logic.
//
// Contract
// RULE1 - the serial line drives a mark as high and a space as low.
// RULE2 - the serial line sits at mark while the transmitter is off, in master reset, when empty, or in loop mode.
// RULE3 - clear-to-send never gates or changes serial line activity, it only feeds status.
// RULE4 - status bit 4 shows the current logical state of the active-low clear-to-send pin.
// RULE5 - any clear-to-send pin change since the last status read sets the change flag in bit 0.
// RULE6 - host software should not send while clear-to-send is inactive high; the device does not enforce it.
// RULE7 - in loop mode the clear-to-send pin has no influence on loop operation.
// RULE8 - data-set-ready is mirrored in status and bit 1 flags a change since the previous status read.
// RULE9 - writing one to control bit 0 drives terminal-ready low, writing zero drives it high.
// RULE10 - master reset clears the control bit so terminal-ready goes inactive high.
// RULE11 - a status read clears both change flags so later changes are relative to that read.
`timescale 1ns/1ps
`default_nettype none
module mhp_modem_pins
    import mhp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic master_reset_in,
    input wire logic tx_enable_in,
    input wire logic tx_empty_in,
    input wire logic loop_mode_in,
    input wire logic tx_bit_in,
    input wire logic cts_b_in,
    input wire logic dsr_b_in,
    input wire logic ctrl_wr_in,
    input wire logic [MHP_MCR_W-1:0] ctrl_wdata_in,
    input wire logic status_rd_in,
    output logic serial_tx_line_out,
    output logic dtr_b_out,
    output logic [MHP_MCR_W-1:0] modem_ctrl_reg_out,
    output logic [MHP_MSR_W-1:0] modem_state_reg_out,
    output logic cts_active_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; reset to inactive high so no false change after reset
    logic [1:0] pins_sync;
    logic cts_b_s;
    logic dsr_b_s;

    mhp_sync #(
        .W(2),
        .RST_VAL(2'h3)
    ) u_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .async_in({dsr_b_in, cts_b_in}),
        .sync_out(pins_sync)
    );

    assign cts_b_s = pins_sync[0];
    assign dsr_b_s = pins_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // serial line: forced to mark whenever idle conditions hold
    logic force_mark;
    logic tx_line_nxt;
    logic tx_line_r;

    // cts deliberately absent here: it never gates the line
    assign force_mark = !tx_enable_in || master_reset_in || tx_empty_in || loop_mode_in; // RULE2 RULE3 RULE7
    assign tx_line_nxt = force_mark ? MHP_MARK : tx_bit_in; // RULE1 RULE2

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            tx_line_r <= MHP_MARK;
        else
            tx_line_r <= tx_line_nxt;
    end

    assign serial_tx_line_out = tx_line_r; // RULE1

    ////////////////////////////////////////////////////////////////////////////////
    // modem control register
    logic [MHP_MCR_W-1:0] modem_ctrl_reg_r;
    logic [MHP_MCR_W-1:0] modem_ctrl_reg_nxt;
    logic dtr_b_r;

    // master reset wins over a same-cycle write
    assign modem_ctrl_reg_nxt = master_reset_in ? MHP_MCR_RST : // RULE10
                                ctrl_wr_in ? ctrl_wdata_in : modem_ctrl_reg_r; // RULE9

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            modem_ctrl_reg_r <= MHP_MCR_RST;
            dtr_b_r <= 1'h1;
        end
        else
        begin
            modem_ctrl_reg_r <= modem_ctrl_reg_nxt;
            dtr_b_r <= !modem_ctrl_reg_nxt[MHP_MCR_DTR_BIT]; // RULE9 RULE10
        end
    end

    assign modem_ctrl_reg_out = modem_ctrl_reg_r;
    assign dtr_b_out = dtr_b_r;

    ////////////////////////////////////////////////////////////////////////////////
    // modem status: live bits plus sticky change flags
    logic cts_prev_r;
    logic dsr_prev_r;
    logic cts_change_flag_r;
    logic dsr_change_flag_r;
    logic cts_chg;
    logic dsr_chg;
    logic cts_change_flag_nxt;
    logic dsr_change_flag_nxt;
    logic [MHP_MSR_W-1:0] status_word;

    assign cts_chg = cts_b_s ^ cts_prev_r;
    assign dsr_chg = dsr_b_s ^ dsr_prev_r;
    // a change in the read cycle survives the clear
    assign cts_change_flag_nxt = cts_chg || (cts_change_flag_r && !status_rd_in); // RULE5 RULE11
    assign dsr_change_flag_nxt = dsr_chg || (dsr_change_flag_r && !status_rd_in); // RULE8 RULE11

    always_comb
    begin
        status_word = MHP_MSR_RST;
        status_word[MHP_MSR_CTS_CHANGE_FLAG_BIT] = cts_change_flag_r; // RULE5
        status_word[MHP_MSR_DSR_CHANGE_FLAG_BIT] = dsr_change_flag_r; // RULE8
        status_word[MHP_MSR_CTS_BIT] = !cts_prev_r; // RULE4
        status_word[MHP_MSR_DSR_BIT] = !dsr_prev_r; // RULE8
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cts_prev_r <= 1'h1;
            dsr_prev_r <= 1'h1;
            cts_change_flag_r <= 1'h0;
            dsr_change_flag_r <= 1'h0;
        end
        else
        begin
            cts_prev_r <= cts_b_s;
            dsr_prev_r <= dsr_b_s;
            cts_change_flag_r <= cts_change_flag_nxt;
            dsr_change_flag_r <= dsr_change_flag_nxt;
        end
    end

    assign modem_state_reg_out = status_word;
    // status only; software decides whether to send
    assign cts_active_out = !cts_prev_r; // RULE6
endmodule : mhp_modem_pins
`default_nettype wire

// >>> mhp_modem.sv
// modem model: clear-to-send on command, data-set-ready follows terminal-ready
// assumes the bench clock; dsr moves just after a rising edge, cts follows cts_on_in at once
`timescale 1ns/1ps
`default_nettype none
module mhp_modem (
    input wire logic mclk_in,
    input wire logic cts_on_in,
    input wire logic dtr_b_in,
    output logic cts_b_out,
    output logic dsr_b_out
);
    // two-cycle lag, a slow modem answering terminal-ready
    logic [1:0] lag_r = 2'h3;
    always @(posedge mclk_in) lag_r <= {lag_r[0], dtr_b_in};
    assign cts_b_out = !cts_on_in;
    assign dsr_b_out = lag_r[1];
endmodule : mhp_modem
`default_nettype wire

// >>> mhp_modem_pins_checker.sv
// assertions on the modem pin block ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
`default_nettype none
module mhp_modem_pins_checker
    import mhp_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic master_reset_in,
    input wire logic tx_enable_in,
    input wire logic tx_empty_in,
    input wire logic loop_mode_in,
    input wire logic tx_bit_in,
    input wire logic ctrl_wr_in,
    input wire logic [MHP_MCR_W-1:0] ctrl_wdata_in,
    input wire logic status_rd_in,
    input wire logic serial_tx_line_out,
    input wire logic dtr_b_out,
    input wire logic [MHP_MCR_W-1:0] modem_ctrl_reg_out,
    input wire logic [MHP_MSR_W-1:0] modem_state_reg_out,
    input wire logic cts_active_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic go = tx_enable_in && !tx_empty_in && !loop_mode_in && !master_reset_in;
    wire logic [7:0] st = modem_state_reg_out;
    sequence s_rd_calm; status_rd_in ##1 $stable(st[5:4]); endsequence
    property p_line; serial_tx_line_out == ($past(go) ? $past(tx_bit_in) : 1'h1); endproperty
    a_line: assert property (p_line) else $error("line");
    property p_wr; ctrl_wr_in && !master_reset_in |=> modem_ctrl_reg_out == $past(ctrl_wdata_in);
    endproperty
    a_wr: assert property (p_wr) else $error("ctrl write");
    property p_dtr; dtr_b_out == !modem_ctrl_reg_out[MHP_MCR_DTR_BIT]; endproperty
    a_dtr: assert property (p_dtr) else $error("dtr");
    property p_mr; master_reset_in |=> dtr_b_out && modem_ctrl_reg_out == 8'h00; endproperty
    a_mr: assert property (p_mr) else $error("mreset");
    property p_cts; $changed(st[4]) |-> st[0] && cts_active_out == st[4]; endproperty
    a_cts: assert property (p_cts) else $error("cts");
    property p_dsr; $changed(st[5]) |-> st[1]; endproperty
    a_dsr: assert property (p_dsr) else $error("dsr");
    property p_clr; s_rd_calm |-> st[1:0] == 2'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_hold; st[0] && !status_rd_in |=> st[0]; endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule : mhp_modem_pins_checker
bind mhp_modem_pins mhp_modem_pins_checker i_chk (.*);
`default_nettype wire

// >>> mhp_modem_pins_test.sv
// bench for the modem pin block with a modem model on the pins
// assumes 40 MHz clock; inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", w, e, g); end end
module mhp_modem_pins_test import mhp_pkg::*; ;
    logic mclk_in = 0, rst_b_in = 0, master_reset_in = 0, tx_enable_in = 0, tx_empty_in = 1;
    logic loop_mode_in = 0, tx_bit_in = 0, ctrl_wr_in = 0, status_rd_in = 0, cts_on = 0;
    logic [7:0] ctrl_wdata_in = 8'h00, modem_ctrl_reg_out, modem_state_reg_out;
    logic cts_b_in, dsr_b_in, serial_tx_line_out, dtr_b_out, cts_active_out;
    int n_checks = 0, n_mismatch = 0;
    always #12.5 mclk_in = !mclk_in;
    mhp_modem_pins i_dut (.*);
    mhp_modem i_modem (.mclk_in, .cts_on_in(cts_on), .dtr_b_in(dtr_b_out),
        .cts_b_out(cts_b_in), .dsr_b_out(dsr_b_in));
    task automatic wr(input logic [7:0] d);
        ctrl_wr_in = 1;
        ctrl_wdata_in = d;
        @(negedge mclk_in) ctrl_wr_in = 0;
        `CHK("dtr", !d[0], dtr_b_out)
    endtask : wr
    task automatic rd(input logic [7:0] e);
        status_rd_in = 1;
        `CHK("msr", e, modem_state_reg_out)
        @(negedge mclk_in) status_rd_in = 0;
    endtask : rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #50000 n_mismatch++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(negedge mclk_in);
        rst_b_in = 1;
        for (int i = 0; i < 32; i++)
        begin
            {tx_enable_in, tx_empty_in, loop_mode_in, master_reset_in, tx_bit_in} = 5'(i);
            cts_on = i[2]; // cts toggles with the loop mode bit; it must not touch the line
            @(negedge mclk_in);
            `CHK("line", (i[4:1] == 4'h8) ? tx_bit_in : 1'h1, serial_tx_line_out)
        end
        {cts_on, master_reset_in} = 2'h0;
        repeat (4) @(negedge mclk_in);
        rd(8'h01);
        `CHK("cts_act", 1'h0, cts_active_out)
        $display("test line done");
        wr(8'h01);
        wr(8'h00);
        wr(8'hFF);
        {master_reset_in, ctrl_wr_in} = 2'h3; // reset beats the write
        @(negedge mclk_in) {master_reset_in, ctrl_wr_in} = 2'h0;
        `CHK("mcr", 8'h00, modem_ctrl_reg_out)
        // modem lag plus three pin flops: let the last dsr edge settle
        repeat (8) @(negedge mclk_in);
        rd(8'h02);
        $display("test dtr done");
        cts_on = 1;
        repeat (4) @(negedge mclk_in);
        rd(8'h11);
        rd(8'h10);
        // cts must read active now; the bench sends nothing afterwards, it only writes terminal-ready
        `CHK("cts_act", 1'h1, cts_active_out)
        wr(8'h01);
        repeat (5) @(negedge mclk_in);
        rd(8'h32);
        $display("test status done");
        end_sim();
    end
endmodule : mhp_modem_pins_test
`default_nettype wire
